// ==== design/pmi_params.svh ====
// Timing and width constants for the PHY-to-MAC data interface.
// Assumes it is included through pmi_pkg or by files that need the raw figures.
`ifndef PMI_PARAMS_SVH
`define PMI_PARAMS_SVH

// System clock rate
`define PMI_MCLK_HZ 25000000

// Link clock rates per speed
`define PMI_F10_HZ 2500000
`define PMI_F100_HZ 25000000
`define PMI_F1000_HZ 125000000

// Width of a divider half-period count
`define PMI_HALF_W 8

// Half period in mclk cycles, rounded down and never below one cycle
`define PMI_HALF_OF(f) (((`PMI_MCLK_HZ / (2 * (f))) < 1) ? 1 : (`PMI_MCLK_HZ / (2 * (f))))
`define PMI_HALF10 `PMI_HALF_OF(`PMI_F10_HZ)
`define PMI_HALF100 `PMI_HALF_OF(`PMI_F100_HZ)
`define PMI_HALF1000 `PMI_HALF_OF(`PMI_F1000_HZ)

`endif

// ==== design/pmi_pkg.sv ====
// Types and helper functions shared by both ends of the data interface.
// Assumes pmi_params.svh is on the include path.
package pmi_pkg;
`include "pmi_params.svh"

  // Interface mode, one-hot
  typedef enum logic [3:0] {
    PMI_MII10 = 4'h1,
    PMI_MII100 = 4'h2,
    PMI_GMII = 4'h4,
    PMI_RGMII = 4'h8
  } pmi_mode_t;

  // Kind of transmit unit handed to the line coder
  typedef enum logic [3:0] {
    PMI_TXC_IDLE = 4'h1,
    PMI_TXC_DATA = 4'h2,
    PMI_TXC_INVALID = 4'h4,
    PMI_TXC_HALT = 4'h8
  } pmi_txcode_t;

  // Nibble-mode transmit error sequencing
  typedef enum logic [1:0] {
    PMI_TX_RUN = 2'h1,
    PMI_TX_HALT = 2'h2
  } pmi_txst_t;

  typedef logic [`PMI_HALF_W-1:0] pmi_half_t;

  // Divider half period for the current speed
  function automatic pmi_half_t pmi_half(input pmi_mode_t m);
    case (m)
      PMI_MII10: pmi_half = pmi_half_t'(`PMI_HALF10);
      PMI_MII100: pmi_half = pmi_half_t'(`PMI_HALF100);
      default: pmi_half = pmi_half_t'(`PMI_HALF1000);
    endcase
  endfunction : pmi_half

  function automatic logic pmi_is_mii(input pmi_mode_t m);
    pmi_is_mii = (m == PMI_MII10) || (m == PMI_MII100);
  endfunction : pmi_is_mii

  // Byte-mode unit kind: an error inside a frame becomes an invalid code-group
  function automatic pmi_txcode_t pmi_frame_code(input logic en, input logic er);
    if (en && er) begin
      pmi_frame_code = PMI_TXC_INVALID;
    end else if (en) begin
      pmi_frame_code = PMI_TXC_DATA;
    end else begin
      pmi_frame_code = PMI_TXC_IDLE;
    end
  endfunction : pmi_frame_code

endpackage : pmi_pkg

// ==== design/pmi_if.sv ====
// Pin bundle between the PHY end and the MAC end.
// Assumes both ends run on the same mclk; every pin here is a plain level.
interface pmi_if;
  // Transmit direction
  logic tx_clk;
  logic gtx_clk;
  logic [7:0] txd;
  logic tx_en;
  logic tx_er;
  // Receive direction
  logic rx_clk;
  logic [2:0] rxd;
  logic rx_dv;

  modport phy (
    input gtx_clk,
    input txd,
    input tx_en,
    input tx_er,
    output tx_clk,
    output rx_clk,
    output rxd,
    output rx_dv
  );

  modport mac (
    output gtx_clk,
    output txd,
    output tx_en,
    output tx_er,
    input tx_clk,
    input rx_clk,
    input rxd,
    input rx_dv
  );
endinterface : pmi_if

// ==== design/pmi_clk_div.sv ====
// Link clock divider: a square wave from mclk plus edge-ahead strobes.
// Assumes half stays steady while run is high; a change takes effect at once, on the count already running.
module pmi_clk_div
  import pmi_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire pmi_half_t half,
  // Divided clock and strobes for the coming edge
  output logic clk_q,
  output logic rise,
  output logic fall
);

  pmi_half_t cnt_q;
  logic wrap;

  // Strobes mark the mclk edge at which clk_q toggles, so launches line up with it
  assign wrap = run & ~rst & (cnt_q >= (half - 8'h01));
  assign rise = wrap & ~clk_q;
  assign fall = wrap & clk_q;

  // Counter and output; stopping parks the clock low
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      cnt_q <= 8'h00;
      clk_q <= 1'b0;
    end else if (wrap) begin
      cnt_q <= 8'h00;
      clk_q <= ~clk_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

endmodule : pmi_clk_div

// ==== design/pmi_phy.sv ====
// PHY end of the MAC-facing data interface: captures transmit units from
// the MAC and launches receive units toward it.
// Assumes a single mclk; the MAC's clock and data pins are foreign and are
// sampled through two flip-flops before any logic looks at them.
module pmi_phy
  import pmi_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Operating mode, held steady while traffic runs
  input wire pmi_mode_t mode,
  // Link pins
  pmi_if.phy link,
  // Transmit units toward the line coder
  output logic tx_stb_q,
  output pmi_txcode_t tx_code_q,
  output logic [7:0] tx_data_q,
  // Receive units from the line decoder
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_err,
  output logic rx_take
);

  logic mii;
  logic ddr;
  logic gmii;
  pmi_half_t half;

  // Mode decode shared by both directions
  assign mii = pmi_is_mii(mode);
  assign gmii = (mode == PMI_GMII);
  assign ddr = (mode == PMI_RGMII);
  assign half = pmi_half(mode);

  // Transmit clock
  logic txc_rise;

  // Only generated in nibble modes; in byte modes the MAC owns the transmit clock
  pmi_clk_div u_txc (
    .mclk(mclk),
    .rst(rst),
    .run(mii),
    .half(half),
    .clk_q(link.tx_clk),
    .rise(txc_rise),
    .fall()
  );

  // Receive clock
  logic rxc_rise;
  logic rxc_fall;

  // Runs in every mode so the MAC always has a receive reference
  pmi_clk_div u_rxc (
    .mclk(mclk),
    .rst(rst),
    .run(1'b1),
    .half(half),
    .clk_q(link.rx_clk),
    .rise(rxc_rise),
    .fall(rxc_fall)
  );

  // Transmit pin synchroniser
  logic [10:0] tsy1_q;
  logic [10:0] tsy2_q;
  logic [10:0] tsy3_q;

  // Clock and data pass the same chain, so a detected edge sees the
  // pre-edge data in the third stage; the first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      tsy1_q <= 11'h000;
      tsy2_q <= 11'h000;
      tsy3_q <= 11'h000;
    end else begin
      tsy1_q <= {link.gtx_clk, link.tx_er, link.tx_en, link.txd};
      tsy2_q <= tsy1_q;
      tsy3_q <= tsy2_q;
    end
  end

  // Edges of the MAC-driven transmit clock and the captured pins
  logic gtx_rise;
  logic gtx_fall;
  logic [7:0] s_txd;
  logic s_en;
  logic s_er;

  assign gtx_rise = tsy2_q[10] & ~tsy3_q[10];
  assign gtx_fall = ~tsy2_q[10] & tsy3_q[10];
  assign s_txd = tsy3_q[7:0];
  assign s_en = tsy3_q[8];
  assign s_er = tsy3_q[9];

  // Sampling strobes per mode
  logic smp_mii;
  logic smp_gmii;
  logic smp_rlo;
  logic smp_rhi;

  // Nibble modes sample on our own clock, byte modes on the MAC clock
  assign smp_mii = mii & txc_rise;
  assign smp_gmii = gmii & gtx_rise;
  // A falling edge shows the low half launched at the rising edge before it
  assign smp_rlo = ddr & gtx_fall;
  assign smp_rhi = ddr & gtx_rise;

  // Nibble-mode error sequencer
  pmi_txst_t txst_q;

  // First errored nibble is invalid, the rest halt until the error drops
  always_ff @(posedge mclk) begin
    if (rst) begin
      txst_q <= PMI_TX_RUN;
    end else if (smp_mii) begin
      txst_q <= s_er ? PMI_TX_HALT : PMI_TX_RUN;
    end else if (!mii) begin
      txst_q <= PMI_TX_RUN;
    end
  end

  // Low half of a double-rate byte
  logic [3:0] rlo_q;
  logic ren_q;

  // Upper pins are never looked at here; only the low nibble counts
  always_ff @(posedge mclk) begin
    if (rst) begin
      rlo_q <= 4'h0;
      ren_q <= 1'b0;
    end else if (smp_rlo) begin
      rlo_q <= s_txd[3:0];
      ren_q <= s_en;
    end
  end

  // Transmit unit register
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_stb_q <= 1'b0;
      tx_code_q <= PMI_TXC_IDLE;
      tx_data_q <= 8'h00;
    end else begin
      tx_stb_q <= smp_mii | smp_gmii | smp_rhi;
      if (smp_mii) begin
        tx_data_q <= {4'h0, s_txd[3:0]};
        case (1'b1)
          s_er: begin
            tx_code_q <= (txst_q == PMI_TX_RUN) ? PMI_TXC_INVALID : PMI_TXC_HALT;
          end
          s_en: begin
            tx_code_q <= PMI_TXC_DATA;
          end
          default: begin
            tx_code_q <= PMI_TXC_IDLE;
          end
        endcase
      end else if (smp_gmii) begin
        tx_data_q <= s_txd;
        tx_code_q <= pmi_frame_code(s_en, s_er);
      end else if (smp_rhi) begin
        tx_data_q <= {s_txd[3:0], rlo_q};
        // Second-edge level is enable xor error
        tx_code_q <= pmi_frame_code(ren_q, ren_q ^ s_en);
      end
    end
  end

  // Receive launch strobes
  logic rxl_hi;

  // The line side must hold its unit until rx_take; there is no buffer here
  assign rx_take = rxc_rise;
  assign rxl_hi = ddr & rxc_fall;

  // Held second half for double-rate receive
  logic [2:0] rhi_q;
  logic rctl_q;

  // Pins change only at receive clock edges, so the MAC always sees settled data.
  // Bits 0-2 leave this block, and bits 4-6 as well in double-rate mode; in nibble and byte modes rx_err has no pin.
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.rxd <= 3'h0;
      link.rx_dv <= 1'b0;
      rhi_q <= 3'h0;
      rctl_q <= 1'b0;
    end else if (rxc_rise) begin
      link.rxd <= rx_data[2:0];
      link.rx_dv <= rx_valid;
      rhi_q <= rx_data[6:4];
      rctl_q <= rx_valid ^ rx_err;
    end else if (rxl_hi) begin
      link.rxd <= rhi_q;
      link.rx_dv <= rctl_q;
    end
  end

endmodule : pmi_phy

// ==== design/pmi_mac.sv ====
// MAC end of the data interface: launches transmit units and captures
// receive units.
// Assumes a single mclk; the PHY's clocks and data are sampled through two
// flip-flops, and the GTX clock is made here by a divider.
module pmi_mac
  import pmi_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Operating mode, held steady while traffic runs
  input wire pmi_mode_t mode,
  // Link pins
  pmi_if.mac link,
  // Transmit units from the MAC core
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_err,
  output logic tx_take,
  // Receive units toward the MAC core
  output logic rx_stb_q,
  output logic [5:0] rx_data_q,
  output logic rx_dv_q,
  output logic rx_err_q
);

  logic mii;
  logic ddr;
  logic gtx_rise;
  logic gtx_fall;

  assign mii = pmi_is_mii(mode);
  assign ddr = (mode == PMI_RGMII);

  // GTX clock runs without pause in byte modes
  pmi_clk_div u_gtx (
    .mclk(mclk),
    .rst(rst),
    .run(~mii),
    .half(pmi_half(mode)),
    .clk_q(link.gtx_clk),
    .rise(gtx_rise),
    .fall(gtx_fall)
  );

  // Receive and clock pin synchroniser; first stage feeds only the second
  logic [5:0] msy1_q;
  logic [5:0] msy2_q;
  logic [5:0] msy3_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      msy1_q <= 6'h00;
      msy2_q <= 6'h00;
      msy3_q <= 6'h00;
    end else begin
      msy1_q <= {link.tx_clk, link.rx_clk, link.rx_dv, link.rxd};
      msy2_q <= msy1_q;
      msy3_q <= msy2_q;
    end
  end

  logic txc_rise;
  logic rxc_rise;
  logic rxc_fall;
  logic tl_lo;
  logic tl_hi;

  assign txc_rise = msy2_q[5] & ~msy3_q[5];
  assign rxc_rise = msy2_q[4] & ~msy3_q[4];
  assign rxc_fall = ~msy2_q[4] & msy3_q[4];

  // Launch on the PHY clock in nibble modes, on our own clock otherwise
  assign tl_lo = mii ? txc_rise : gtx_rise;
  assign tl_hi = ddr & gtx_fall;
  assign tx_take = tl_lo;

  logic [3:0] thi_q;
  logic tctl_q;

  // Transmit launch; upper pins stay low outside GMII
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.txd <= 8'h00;
      link.tx_en <= 1'b0;
      link.tx_er <= 1'b0;
      thi_q <= 4'h0;
      tctl_q <= 1'b0;
    end else if (tl_lo) begin
      if (mode == PMI_GMII) begin
        link.txd <= tx_data;
      end else begin
        link.txd <= {4'h0, tx_data[3:0]};
      end
      link.tx_en <= tx_valid;
      link.tx_er <= ddr ? 1'b0 : tx_err;
      thi_q <= tx_data[7:4];
      tctl_q <= tx_valid ^ tx_err;
    end else if (tl_hi) begin
      link.txd <= {4'h0, thi_q};
      link.tx_en <= tctl_q;
    end
  end

  logic [2:0] rlo_q;
  logic rdv_q;

  // Receive capture: a fall shows the first half, a rise completes the unit
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_stb_q <= 1'b0;
      rx_data_q <= 6'h00;
      rx_dv_q <= 1'b0;
      rx_err_q <= 1'b0;
      rlo_q <= 3'h0;
      rdv_q <= 1'b0;
    end else begin
      rx_stb_q <= rxc_rise;
      if (ddr && rxc_fall) begin
        rlo_q <= msy3_q[2:0];
        rdv_q <= msy3_q[3];
      end else if (rxc_rise && ddr) begin
        rx_data_q <= {msy3_q[2:0], rlo_q};
        rx_dv_q <= rdv_q;
        rx_err_q <= rdv_q ^ msy3_q[3];
      end else if (rxc_rise) begin
        rx_data_q <= {3'h0, msy3_q[2:0]};
        rx_dv_q <= msy3_q[3];
        rx_err_q <= 1'b0;
      end
    end
  end

endmodule : pmi_mac

// ==== bench/pmi_props.sv ====
// Pin-level checks on the bundle that joins the two ends of the data interface.
// Assumes one mclk for both ends and that the mode changes only while in reset.
module pmi_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Transmit pins
  input wire logic tx_clk,
  input wire logic gtx_clk,
  input wire logic [7:0] txd,
  input wire logic tx_en,
  input wire logic tx_er,
  // Receive pins
  input wire logic rx_clk,
  input wire logic [2:0] rxd,
  input wire logic rx_dv
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Divided clock high for five or for one mclk cycle, then low
  sequence s_half5(c);
    c [*5] ##1 !c;
  endsequence
  sequence s_half1(c);
    c ##1 !c;
  endsequence
  // MII transmit clock keeps running while the GTX clock rests
  property p_tx_clk_runs;
    $rose(tx_clk) |-> !gtx_clk ##[1:12] $rose(tx_clk);
  endproperty
  a_tx_clk_runs: assert property (p_tx_clk_runs) else $error("tx clock stopped");
  property p_tx_clk_rate;
    $rose(tx_clk) |-> s_half5(tx_clk) or s_half1(tx_clk);
  endproperty
  a_tx_clk_rate: assert property (p_tx_clk_rate) else $error("tx clock rate");
  // GTX clock toggles every cycle in byte modes, never beside the MII clock
  property p_gtx_runs;
    $rose(gtx_clk) |-> !tx_clk ##1 !gtx_clk ##1 gtx_clk;
  endproperty
  a_gtx_runs: assert property (p_gtx_runs) else $error("gtx clock rate");
  property p_rx_clk_rate;
    $rose(rx_clk) |-> s_half5(rx_clk) or s_half1(rx_clk);
  endproperty
  a_rx_clk_rate: assert property (p_rx_clk_rate) else $error("rx clock rate");
  property p_rx_clk_runs;
    $fell(rx_clk) |-> ##[1:5] $rose(rx_clk);
  endproperty
  a_rx_clk_runs: assert property (p_rx_clk_runs) else $error("rx clock stopped");
  // Receive pins move only with a receive clock edge
  property p_rx_sync;
    $changed({rxd, rx_dv}) |-> $changed(rx_clk);
  endproperty
  a_rx_sync: assert property (p_rx_sync) else $error("rx pins off clock");
  // Upper nibble lives only beside a toggling GTX clock
  property p_upper_sync;
    $changed(txd[7:4]) |-> $changed(gtx_clk);
  endproperty
  a_upper_sync: assert property (p_upper_sync) else $error("upper nibble off gtx");
  property p_mii_upper_zero;
    (!gtx_clk && !$past(gtx_clk)) |-> txd[7:4] == 4'h0;
  endproperty
  a_mii_upper_zero: assert property (p_mii_upper_zero) else $error("upper nibble used");
  // Byte-mode launches ride on the GTX clock edges
  property p_byte_launch;
    $changed({txd, tx_en, tx_er}) |-> $changed(gtx_clk) || (!gtx_clk && !$past(gtx_clk));
  endproperty
  a_byte_launch: assert property (p_byte_launch) else $error("byte launch off gtx");
  // MII launch lands three cycles after the PHY's clock rise is seen
  property p_mii_launch;
    ($changed(txd[3:0]) && !gtx_clk && !$past(gtx_clk)) |-> $past(tx_clk, 3) && !$past(tx_clk, 4);
  endproperty
  a_mii_launch: assert property (p_mii_launch) else $error("mii launch timing");
endmodule : pmi_props

// ==== bench/tb.sv ====
// Self-checking bench: both ends joined by the pin bundle, every mode exercised.
// Assumes pmi_pkg, the interface and both ends are compiled first.
module tb
  import pmi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Driven inputs
  logic mclk = 1'b0;
  logic rst = 1'b1;
  pmi_mode_t mode = PMI_MII10;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_err = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_err = 1'b0;
  // Observed outputs
  logic tx_stb, tx_take, rx_take, rx_stb, rx_dvo, rx_erro;
  pmi_txcode_t tx_code;
  logic [7:0] tx_dat;
  logic [5:0] rx_dat;
  int err_total = 0;
  int checks_done = 0;
  pmi_txcode_t cq[$];
  logic [7:0] dq[$];
  logic [7:0] rq[$];

  pmi_if lk ();
  pmi_phy u_pmi_phy (.mclk(mclk), .rst(rst), .mode(mode), .link(lk.phy), .tx_stb_q(tx_stb),
    .tx_code_q(tx_code), .tx_data_q(tx_dat), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_err(rx_err), .rx_take(rx_take));
  pmi_mac u_pmi_mac (.mclk(mclk), .rst(rst), .mode(mode), .link(lk.mac), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_err(tx_err), .tx_take(tx_take), .rx_stb_q(rx_stb),
    .rx_data_q(rx_dat), .rx_dv_q(rx_dvo), .rx_err_q(rx_erro));
  pmi_props u_pmi_props (.mclk(mclk), .rst(rst), .tx_clk(lk.tx_clk), .gtx_clk(lk.gtx_clk),
    .txd(lk.txd), .tx_en(lk.tx_en), .tx_er(lk.tx_er), .rx_clk(lk.rx_clk), .rxd(lk.rxd),
    .rx_dv(lk.rx_dv));

  // System clock, 40 ns period
  always #20 mclk = ~mclk;

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Idle units are dropped so pipeline depth never shifts the expected order.
  // Sampled mid-cycle, where the one-cycle strobes have settled.
  always @(negedge mclk) begin
    if (tx_stb === 1'b1 && tx_code !== PMI_TXC_IDLE) begin
      cq.push_back(tx_code);
      dq.push_back(tx_dat);
    end
    if (rx_stb === 1'b1 && rx_dvo === 1'b1) begin
      rq.push_back({1'b0, rx_erro, rx_dat});
    end
    if (mode == PMI_RGMII && rst === 1'b0) begin
      chk(8'(lk.tx_er), 8'h00);
    end
  end

  // Mode changes only under reset; sync chains refill before traffic
  task automatic start(input pmi_mode_t m);
    rst = 1'b1;
    mode = m;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    cq.delete();
    dq.delete();
    rq.delete();
    repeat (4) @(negedge mclk);
  endtask : start

  // One unit held until its take strobe, bounded
  task automatic send(input logic rx, input logic [7:0] d, input logic e);
    int i;
    if (rx) begin
      rx_valid = 1'b1;
      rx_data = d;
      rx_err = e;
    end else begin
      tx_valid = 1'b1;
      tx_data = d;
      tx_err = e;
    end
    for (i = 0; i < 60; i++) begin
      if ((rx ? rx_take : tx_take) === 1'b1) break;
      @(negedge mclk);
    end
    if (i == 60) begin
      err_total++;
      end_sim();
    end else begin
      @(negedge mclk);
    end
  endtask : send

  task automatic settle;
    tx_valid = 1'b0;
    rx_valid = 1'b0;
    repeat (80) @(negedge mclk);
  endtask : settle

  task automatic tx_seq;
    send(1'b0, 8'hA5, 1'b0);
    send(1'b0, 8'h3C, 1'b1);
    send(1'b0, 8'h3C, 1'b1);
    send(1'b0, 8'h5A, 1'b0);
    settle();
  endtask : tx_seq

  task automatic rx_seq;
    send(1'b1, 8'hFD, 1'b1);
    send(1'b1, 8'h12, 1'b0);
    settle();
  endtask : rx_seq

  task automatic chk_tx(input pmi_txcode_t c, input logic [7:0] d);
    logic [7:0] gc;
    logic [7:0] gd;
    gc = 8'hFF;
    gd = 8'hFF;
    if (cq.size() > 0) begin
      gc = 8'(cq.pop_front());
      gd = dq.pop_front();
    end
    chk(gc, 8'(c));
    if (c == PMI_TXC_DATA) chk(gd, d);
  endtask : chk_tx

  task automatic chk_rx(input logic [7:0] exp);
    logic [7:0] got;
    got = 8'hFF;
    if (rq.size() > 0) got = rq.pop_front();
    chk(got, exp);
  endtask : chk_rx

  // Link clock toggles over 20 mclk cycles: 4 at 2.5MHz, 20 at the fastest rate
  // a 25MHz mclk can make; a stopped clock shows none
  task automatic chk_rate(input logic [7:0] etx, input logic [7:0] egtx, input logic [7:0] erx);
    logic [7:0] ntx;
    logic [7:0] ngtx;
    logic [7:0] nrx;
    logic [2:0] prv;
    ntx = 8'h00;
    ngtx = 8'h00;
    nrx = 8'h00;
    prv = {lk.tx_clk, lk.gtx_clk, lk.rx_clk};
    repeat (20) begin
      @(negedge mclk);
      if (lk.tx_clk !== prv[2]) ntx++;
      if (lk.gtx_clk !== prv[1]) ngtx++;
      if (lk.rx_clk !== prv[0]) nrx++;
      prv = {lk.tx_clk, lk.gtx_clk, lk.rx_clk};
    end
    chk(ntx, etx);
    chk(ngtx, egtx);
    chk(nrx, erx);
  endtask : chk_rate

  // Nibble mode: upper bits dropped, error gives invalid then halt
  task automatic t_mii10;
    start(PMI_MII10);
    chk_rate(8'h04, 8'h00, 8'h04);
    tx_seq();
    chk_tx(PMI_TXC_DATA, 8'h05);
    chk_tx(PMI_TXC_INVALID, 8'h00);
    chk_tx(PMI_TXC_HALT, 8'h00);
    chk_tx(PMI_TXC_DATA, 8'h0A);
    chk(8'(cq.size()), 8'h00);
    rx_seq();
    chk_rx(8'h05);
    chk_rx(8'h02);
    chk(8'(rq.size()), 8'h00);
  endtask : t_mii10

  // Fast nibble mode checked on clock rates and receive traffic only
  task automatic t_mii100;
    start(PMI_MII100);
    chk_rate(8'h14, 8'h00, 8'h14);
    rx_seq();
    chk_rx(8'h05);
    chk_rx(8'h02);
    chk(8'(rq.size()), 8'h00);
  endtask : t_mii100

  task automatic t_gmii;
    start(PMI_GMII);
    chk_rate(8'h00, 8'h14, 8'h14);
    tx_seq();
    chk_tx(PMI_TXC_DATA, 8'hA5);
    chk_tx(PMI_TXC_INVALID, 8'h00);
    chk_tx(PMI_TXC_INVALID, 8'h00);
    chk_tx(PMI_TXC_DATA, 8'h5A);
    chk(8'(cq.size()), 8'h00);
    rx_seq();
    chk_rx(8'h05);
    chk_rx(8'h02);
    chk(8'(rq.size()), 8'h00);
  endtask : t_gmii

  // Both edges carry data and the control pin carries the error
  task automatic t_rgmii;
    start(PMI_RGMII);
    chk_rate(8'h00, 8'h14, 8'h14);
    tx_seq();
    chk_tx(PMI_TXC_DATA, 8'hA5);
    chk_tx(PMI_TXC_INVALID, 8'h00);
    chk_tx(PMI_TXC_INVALID, 8'h00);
    chk_tx(PMI_TXC_DATA, 8'h5A);
    chk(8'(cq.size()), 8'h00);
    rx_seq();
    chk_rx(8'h7D);
    chk_rx(8'h0A);
    chk(8'(rq.size()), 8'h00);
  endtask : t_rgmii

  initial begin
    repeat (6) @(negedge mclk);
    t_mii10();
    t_mii100();
    t_gmii();
    t_rgmii();
    end_sim();
  end
endmodule : tb
